// File: udma_consts.svh
// Constants for the UART DMA ready signalling block
// How it works
// [R1] FIFO mode: select bit picks DMA type
// [R2] Non-FIFO mode forces DMA mode 0
// [R3] Mode 0 single transfer, mode 1 burst
// [R4] Mode 0: rx request low when data held
// [R5] Mode 0: rx request high when empty
// [R6] Mode 1: rx request at trigger or timeout
// [R7] Mode 1: rx request held until empty
// [R8] Mode 1: tx request held until full
// [R9] Master reset forces serial output high
// [R10] Write taken when selected and either strobe
// [R11] Host uses one write strobe only
// [R12] Oscillator output inverts external clock input
// [R13] Sleep floats the oscillator output
// [R14] Read answered when selected and either strobe
// [R15] Mode 0: tx request low while empty
// [R16] Mode 1: tx request low while space
`ifndef UDMA_CONSTS_SVH
`define UDMA_CONSTS_SVH
`define UDMA_FIFO_EN_BIT   0
`define UDMA_DMA_MODE_BIT  3
`define UDMA_FCR_RESET     8'h00
`define UDMA_ADDR_FCR      3'h2
`define UDMA_ADDR_THR      3'h0
`define UDMA_FIFO_DEPTH    64
`define UDMA_RX_TRIGGER    8
`define UDMA_TIMEOUT_CYC   16'h0100
`define UDMA_HOLD_DEPTH    1
`define UDMA_HOLD_CYC      3'h4
`define UDMA_LINE_MARK     1'b1
`endif

// File: udma_pkg.sv
// Package with shared types for the UART DMA ready block
package udma_pkg;
	typedef enum logic [1:0] {
		UDMA_IDLE  = 2'h0,
		UDMA_STRB  = 2'h1,
		UDMA_HOLD  = 2'h3
	} udma_bus_state_t;
endpackage

// File: udma_if.sv
// Interface joining the UART device end to its host end
`timescale 1ns/1ps
interface udma_if;
	logic       sel;
	logic       wr_n;
	logic       wr;
	logic       rd_n;
	logic       rd;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rdata_oe;
	logic       rx_dma_request_n;
	logic       tx_dma_request_n;
	modport device (input sel, wr_n, wr, rd_n, rd, addr, wdata,
		output rdata, rdata_oe, rx_dma_request_n, tx_dma_request_n);
	modport host (output sel, wr_n, wr, rd_n, rd, addr, wdata,
		input rdata, rdata_oe, rx_dma_request_n, tx_dma_request_n);
endinterface

// File: udma_device.sv
// UART device end: write/read strobes, DMA request lines, tx idle, oscillator pin
`timescale 1ns/1ps
`include "udma_consts.svh"
module udma_device import udma_pkg::*; #(
	parameter int DEPTH   = `UDMA_FIFO_DEPTH,
	parameter int TRIGGER = `UDMA_RX_TRIGGER
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Host bus
	udma_if.device          bus,
	// Receiver side: received characters arrive, time-out event
	input  wire logic       rx_char_valid,
	input  wire logic [7:0] rx_char,
	input  wire logic       rx_timeout,
	// Transmitter side: serializer takes a character
	input  wire logic       tx_char_taken,
	output logic            tx_serial,
	// Oscillator and sleep
	input  wire logic       osc_in,
	input  wire logic       sleep_mode,
	output logic            osc_out,
	output logic            osc_out_oe,
	// Written character seen by the transmitter
	output logic [7:0]      tx_char
);
	localparam int CW = $clog2(DEPTH + 1);
	////////////////////////////////////////////////////////////////////////////////
	// Synchronise strobes and the external clock pin
	logic [1:0] wr_n_s, wr_s, rd_n_s, rd_s, sel_s, osc_s, sleep_s;
	always_ff @(posedge mclk) begin
		wr_n_s  <= {wr_n_s[0], bus.wr_n};
		wr_s    <= {wr_s[0], bus.wr};
		rd_n_s  <= {rd_n_s[0], bus.rd_n};
		rd_s    <= {rd_s[0], bus.rd};
		sel_s   <= {sel_s[0], bus.sel};
		osc_s   <= {osc_s[0], osc_in};
		sleep_s <= {sleep_s[0], sleep_mode};
	end
	// Address and data settle well before the strobe, so a plain two-stage copy is safe
	logic [2:0] addr_s0, addr_s1;
	logic [7:0] wdata_s0, wdata_s1;
	always_ff @(posedge mclk) begin
		addr_s0  <= bus.addr;
		addr_s1  <= addr_s0;
		wdata_s0 <= bus.wdata;
		wdata_s1 <= wdata_s0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Shared decode and occupancy arithmetic
	function automatic logic addr_hit(input logic [2:0] a, input logic [2:0] want);
		return a == want;
	endfunction
	function automatic logic [CW-1:0] store_limit(input logic fifo_on);
		return fifo_on ? CW'(DEPTH) : CW'(`UDMA_HOLD_DEPTH);
	endfunction
	function automatic logic [CW-1:0] next_count(input logic [CW-1:0] cnt, input logic push,
		input logic pop);
		return cnt + CW'(push) - CW'(pop);
	endfunction
	// Either strobe polarity works; the host leaves the other idle
	logic wr_act, rd_act, wr_act_d, rd_act_d, wr_pulse, rd_pulse;
	assign wr_act = sel_s[1] & (~wr_n_s[1] | wr_s[1]); // R10 R11
	assign rd_act = sel_s[1] & (~rd_n_s[1] | rd_s[1]); // R14
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_act_d <= 1'b0;
			rd_act_d <= 1'b0;
		end else begin
			wr_act_d <= wr_act;
			rd_act_d <= rd_act;
		end
	end
	assign wr_pulse = wr_act & ~wr_act_d;
	assign rd_pulse = rd_act & ~rd_act_d;
	////////////////////////////////////////////////////////////////////////////////
	// FIFO control register
	logic [7:0] fifo_control_reg;
	logic       fifo_enable_bit, dma_mode_select_bit, mode1;
	always_ff @(posedge mclk) begin
		if (rst)
			fifo_control_reg <= `UDMA_FCR_RESET;
		else if (wr_pulse && addr_hit(addr_s1, `UDMA_ADDR_FCR))
			fifo_control_reg <= wdata_s1; // R10
	end
	assign fifo_enable_bit     = fifo_control_reg[`UDMA_FIFO_EN_BIT];
	assign dma_mode_select_bit = fifo_control_reg[`UDMA_DMA_MODE_BIT];
	// Non-FIFO mode ignores the select bit
	assign mode1 = fifo_enable_bit & dma_mode_select_bit; // R1 R2 R3
	////////////////////////////////////////////////////////////////////////////////
	// Receive occupancy and data store; holding register is a depth of one
	logic [7:0]    rx_mem [DEPTH];
	logic [CW-1:0] rx_cnt, rx_lim;
	logic [$clog2(DEPTH)-1:0] rx_wp, rx_rp;
	logic rx_push, rx_pop;
	assign rx_lim  = store_limit(fifo_enable_bit);
	// A full store drops the character; overrun reporting lives elsewhere
	assign rx_push = rx_char_valid && rx_cnt < rx_lim;
	assign rx_pop  = rd_pulse && addr_hit(addr_s1, `UDMA_ADDR_THR) && rx_cnt != '0;
	always_ff @(posedge mclk) begin
		if (rst)
			rx_cnt <= '0;
		else
			rx_cnt <= next_count(rx_cnt, rx_push, rx_pop);
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_wp <= '0;
			rx_rp <= '0;
		end else begin
			if (rx_push)
				rx_wp <= rx_wp + 1'b1;
			if (rx_pop)
				rx_rp <= rx_rp + 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (rx_push)
			rx_mem[rx_wp] <= rx_char;
	end
	// Read data drives the bus only during a read
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus.rdata    <= 8'h00;
			bus.rdata_oe <= 1'b0;
		end else begin
			bus.rdata_oe <= rd_act; // R14
			if (rd_pulse)
				bus.rdata <= addr_hit(addr_s1, `UDMA_ADDR_THR) ? rx_mem[rx_rp] :
					fifo_control_reg;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Receive DMA request
	// Mode 1 latches low at trigger or time-out and lets go only when empty
	always_ff @(posedge mclk) begin
		if (rst)
			bus.rx_dma_request_n <= 1'b1;
		else if (!mode1)
			bus.rx_dma_request_n <= (rx_cnt == '0); // R4 R5
		else if (rx_cnt >= CW'(TRIGGER) || (rx_timeout && rx_cnt != '0))
			bus.rx_dma_request_n <= 1'b0; // R6
		else if (rx_cnt == '0)
			bus.rx_dma_request_n <= 1'b1; // R7
	end
	////////////////////////////////////////////////////////////////////////////////
	// Transmit occupancy and DMA request
	logic [7:0]    tx_mem [DEPTH];
	logic [CW-1:0] tx_cnt, tx_lim;
	logic [$clog2(DEPTH)-1:0] tx_wp, tx_rp;
	logic tx_push, tx_pop;
	assign tx_lim  = store_limit(fifo_enable_bit);
	// Writes into a full store are dropped silently
	assign tx_push = wr_pulse && addr_hit(addr_s1, `UDMA_ADDR_THR) && tx_cnt < tx_lim;
	assign tx_pop  = tx_char_taken && tx_cnt != '0;
	always_ff @(posedge mclk) begin
		if (rst)
			tx_cnt <= '0;
		else
			tx_cnt <= next_count(tx_cnt, tx_push, tx_pop);
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_wp <= '0;
			tx_rp <= '0;
		end else begin
			if (tx_push)
				tx_wp <= tx_wp + 1'b1;
			if (tx_pop)
				tx_rp <= tx_rp + 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (tx_push)
			tx_mem[tx_wp] <= wdata_s1;
	end
	always_ff @(posedge mclk) begin
		if (rst)
			tx_char <= 8'h00;
		else
			tx_char <= tx_mem[tx_rp];
	end
	always_ff @(posedge mclk) begin
		if (rst)
			bus.tx_dma_request_n <= 1'b1;
		else if (!mode1)
			bus.tx_dma_request_n <= (tx_cnt != '0); // R15
		else
			bus.tx_dma_request_n <= (tx_cnt == tx_lim); // R8 R16
	end
	////////////////////////////////////////////////////////////////////////////////
	// Serial output idles at mark; shifter lives elsewhere
	always_ff @(posedge mclk) begin
		if (rst)
			tx_serial <= `UDMA_LINE_MARK; // R9
		else
			tx_serial <= `UDMA_LINE_MARK;
	end
	// Oscillator output; sampled copy, so it lags the pin by the synchroniser
	always_ff @(posedge mclk) begin
		if (rst) begin
			osc_out    <= 1'b1;
			osc_out_oe <= 1'b1;
		end else begin
			osc_out    <= ~osc_s[1]; // R12
			osc_out_oe <= ~sleep_s[1]; // R13
		end
	end
endmodule

// File: udma_host.sv
// Host end: issues register writes/reads with one strobe polarity, follows DMA requests
`timescale 1ns/1ps
`include "udma_consts.svh"
module udma_host import udma_pkg::*; #(
	parameter bit USE_HIGH_STROBE = 1'b0
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Device bus
	udma_if.host            bus,
	// User request
	input  wire logic       req,
	input  wire logic       req_write,
	input  wire logic [2:0] req_addr,
	input  wire logic [7:0] req_wdata,
	output logic            busy,
	output logic            done,
	output logic [7:0]      rdata,
	// Request lines seen by the DMA user
	output logic            rx_dma_pending,
	output logic            tx_dma_pending
);
	localparam logic [2:0] HOLD_CYC = `UDMA_HOLD_CYC;
	udma_bus_state_t state;
	logic [2:0]      cnt;
	logic            is_wr;
	logic [1:0]      rxr_s, txr_s;
	// Strobe must outlast the device synchroniser, hence the hold count
	always_ff @(posedge mclk) begin
		if (rst) begin
			state     <= UDMA_IDLE;
			cnt       <= 3'h0;
			is_wr     <= 1'b0;
			bus.wr_n  <= 1'b1;
			bus.wr    <= 1'b0;
			bus.rd_n  <= 1'b1;
			bus.rd    <= 1'b0;
			busy      <= 1'b0;
			done      <= 1'b0;
			rdata     <= 8'h00;
			bus.sel   <= 1'b0;
			bus.addr  <= 3'h0;
			bus.wdata <= 8'h00;
		end else begin
			done <= 1'b0;
			unique case (state)
				UDMA_IDLE: if (req) begin
					bus.sel   <= 1'b1;
					bus.addr  <= req_addr;
					bus.wdata <= req_wdata; // R10
					is_wr     <= req_write;
					busy      <= 1'b1;
					cnt       <= 3'h0;
					state     <= UDMA_STRB;
				end
				UDMA_STRB: begin
					// Only one strobe of each pair moves; the other stays inactive
					bus.wr_n <= ~(is_wr & ~USE_HIGH_STROBE); // R11
					bus.wr   <= is_wr & USE_HIGH_STROBE; // R11
					bus.rd_n <= ~(~is_wr & ~USE_HIGH_STROBE); // R14
					bus.rd   <= ~is_wr & USE_HIGH_STROBE; // R14
					cnt      <= cnt + 3'h1;
					if (cnt == HOLD_CYC) begin
						if (!is_wr)
							rdata <= bus.rdata; // R14
						bus.wr_n <= 1'b1;
						bus.wr   <= 1'b0;
						bus.rd_n <= 1'b1;
						bus.rd   <= 1'b0;
						cnt    <= 3'h0;
						state  <= UDMA_HOLD;
					end
				end
				UDMA_HOLD: begin
					cnt <= cnt + 3'h1;
					if (cnt == HOLD_CYC) begin
						bus.sel <= 1'b0;
						busy    <= 1'b0;
						done    <= 1'b1;
						state   <= UDMA_IDLE;
					end
				end
				default: state <= UDMA_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Request lines; the DMA user decides single or burst transfers
	always_ff @(posedge mclk) begin
		rxr_s <= {rxr_s[0], bus.rx_dma_request_n};
		txr_s <= {txr_s[0], bus.tx_dma_request_n};
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_dma_pending <= 1'b0;
			tx_dma_pending <= 1'b0;
		end else begin
			rx_dma_pending <= ~rxr_s[1]; // R3
			tx_dma_pending <= ~txr_s[1]; // R3 R8
		end
	end
endmodule

// File: udma_checker.sv
// Checker on the bus between the device end and the host end
`timescale 1ns/1ps
module udma_checker import udma_pkg::*; #(
	parameter bit HIGH_STROBE = 1'b1
) (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	// Bus signals
	input wire logic       sel,
	input wire logic       wr_n,
	input wire logic       wr,
	input wire logic       rd_n,
	input wire logic       rd,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       rdata_oe,
	input wire logic       rx_dma_request_n,
	input wire logic       tx_dma_request_n
);
	logic       w_act;
	logic       r_act;
	logic [3:0] age_reg;
	assign w_act = ~wr_n | wr;
	assign r_act = ~rd_n | rd;
	// Cycles since the last strobe; a request only rises soon after bus traffic
	always_ff @(posedge mclk) begin
		if (rst | w_act | r_act) begin
			age_reg <= 4'h0;
		end else if (age_reg != 4'hF) begin
			age_reg <= age_reg + 4'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	chk_spare_strobe: assert property (HIGH_STROBE ? (wr_n && rd_n) : (!wr && !rd))
		else $error("unused strobe moved");
	chk_strobe_len: assert property ($rose(w_act | r_act) |-> (w_act | r_act) [*3])
		else $error("strobe shorter than three cycles");
	chk_sel_held: assert property ((w_act | r_act) |-> sel)
		else $error("strobe without select");
	chk_write_stable: assert property (w_act && $past(w_act) |-> $stable(wdata) && $stable(addr))
		else $error("write data moved under strobe");
	chk_oe_cause: assert property ($rose(rdata_oe) |-> sel && r_act)
		else $error("read data driven without read");
	chk_oe_release: assert property ($fell(r_act) |-> ##[1:4] !rdata_oe)
		else $error("read data still driven");
	chk_tx_rise: assert property ($rose(tx_dma_request_n) |-> age_reg < 4'h8)
		else $error("tx request released without a write");
	chk_rx_rise: assert property ($rose(rx_dma_request_n) |-> age_reg < 4'h8)
		else $error("rx request released without bus access");
	cov_read: cover property ($rose(rdata_oe));
	cov_rx_req: cover property ($fell(rx_dma_request_n));
	cov_tx_full: cover property ($rose(tx_dma_request_n));
endmodule

// File: uart_dma_ready_signaling_test.sv
// Self-checking bench joining the device and host ends
`timescale 1ns/1ps
module uart_dma_ready_signaling_test;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       req = 1'b0;
	logic       req_write = 1'b0;
	logic [2:0] req_addr = 3'h0;
	logic [7:0] req_wdata = 8'h00;
	logic       rx_char_valid = 1'b0;
	logic [7:0] rx_char = 8'h00;
	logic       rx_timeout = 1'b0;
	logic       tx_char_taken = 1'b0;
	logic       osc_in = 1'b0;
	logic       sleep_mode = 1'b0;
	logic       reading = 1'b0;
	logic       busy, done, rx_dma_pending, tx_dma_pending, tx_serial, osc_out, osc_out_oe;
	logic [7:0] rdata, tx_char;
	logic [7:0] rxq[$];
	logic [7:0] expq[$];
	int         fails = 0;
	int         checks_done = 0;
	udma_if bus ();
	udma_device udma_device_i (.mclk, .rst, .bus(bus), .rx_char_valid, .rx_char, .rx_timeout,
		.tx_char_taken, .tx_serial, .osc_in, .sleep_mode, .osc_out, .osc_out_oe, .tx_char);
	udma_host #(.USE_HIGH_STROBE(1'b1)) udma_host_i (.mclk, .rst, .bus(bus), .req, .req_write,
		.req_addr, .req_wdata, .busy, .done, .rdata, .rx_dma_pending, .tx_dma_pending);
	udma_checker #(.HIGH_STROBE(1'b1)) udma_checker_i (.mclk, .rst, .sel(bus.sel),
		.wr_n(bus.wr_n), .wr(bus.wr), .rd_n(bus.rd_n), .rd(bus.rd), .addr(bus.addr),
		.wdata(bus.wdata), .rdata_oe(bus.rdata_oe), .rx_dma_request_n(bus.rx_dma_request_n),
		.tx_dma_request_n(bus.tx_dma_request_n));
	initial begin
		forever #20 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cmp_bit(string name, logic exp, logic got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic cmp_byte(string name, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Inputs always move one nanosecond after the edge
	task automatic tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic access(logic w, logic [2:0] a, logic [7:0] d);
		int i;
		tick(1);
		req = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		reading = !w;
		tick(1);
		req = 1'b0;
		cmp_bit("busy", 1'b1, busy);
		for (i = 0; i < 40 && done !== 1'b1; i++) begin
			tick(1);
		end
		if (i == 40) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic push_rx();
		tick(1);
		rx_char_valid = 1'b1;
		rx_char = 8'($urandom);
		rxq.push_back(rx_char);
		tick(1);
		rx_char_valid = 1'b0;
	endtask
	task automatic rd_rx();
		expq.push_back(rxq.pop_front());
		access(1'b0, 3'h0, 8'h00);
	endtask
	// Read results are matched oldest first against the noted characters
	always @(posedge mclk) begin
		if (done === 1'b1 && reading && expq.size() > 0) begin
			cmp_byte("read data", expq.pop_front(), rdata);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int k;
		void'($urandom(26));
		tick(20);
		rst = 1'b0;
		tick(4);
		cmp_bit("busy", 1'b0, busy);
		cmp_bit("tx line", 1'b1, tx_serial);
		cmp_bit("rx request", 1'b0, rx_dma_pending);
		cmp_bit("tx request", 1'b1, tx_dma_pending);
		push_rx();
		tick(8);
		cmp_bit("rx request", 1'b1, rx_dma_pending);
		rd_rx();
		tick(8);
		cmp_bit("rx request", 1'b0, rx_dma_pending);
		access(1'b1, 3'h0, 8'hA5);
		tick(8);
		cmp_byte("tx char", 8'hA5, tx_char);
		cmp_bit("tx request", 1'b0, tx_dma_pending);
		tx_char_taken = 1'b1;
		tick(1);
		tx_char_taken = 1'b0;
		tick(8);
		cmp_bit("tx request", 1'b1, tx_dma_pending);
		// Mode bit alone must not leave single-transfer signalling
		access(1'b1, 3'h2, 8'h08);
		push_rx();
		tick(8);
		cmp_bit("rx request", 1'b1, rx_dma_pending);
		rd_rx();
		access(1'b1, 3'h2, 8'h09);
		for (k = 0; k < 8; k++) begin
			tick(8);
			cmp_bit("rx request", 1'b0, rx_dma_pending);
			push_rx();
		end
		for (k = 0; k < 8; k++) begin
			tick(8);
			cmp_bit("rx request", 1'b1, rx_dma_pending);
			rd_rx();
		end
		tick(8);
		cmp_bit("rx request", 1'b0, rx_dma_pending);
		push_rx();
		rx_timeout = 1'b1;
		tick(1);
		rx_timeout = 1'b0;
		tick(8);
		cmp_bit("rx request", 1'b1, rx_dma_pending);
		rd_rx();
		tick(8);
		cmp_bit("rx request", 1'b0, rx_dma_pending);
		for (k = 0; k < 64; k++) begin
			cmp_bit("tx request", 1'b1, tx_dma_pending);
			access(1'b1, 3'h0, 8'($urandom));
		end
		tick(8);
		cmp_bit("tx request", 1'b0, tx_dma_pending);
		tx_char_taken = 1'b1;
		tick(1);
		tx_char_taken = 1'b0;
		tick(8);
		cmp_bit("tx request", 1'b1, tx_dma_pending);
		// FIFO on with the mode bit clear keeps single-transfer signalling
		access(1'b1, 3'h2, 8'h01);
		push_rx();
		tick(8);
		cmp_bit("rx request", 1'b1, rx_dma_pending);
		cmp_bit("tx request", 1'b0, tx_dma_pending);
		rd_rx();
		tick(8);
		cmp_bit("rx request", 1'b0, rx_dma_pending);
		for (k = 0; k < 2; k++) begin
			osc_in = k[0];
			tick(6);
			cmp_bit("osc out", ~k[0], osc_out);
		end
		sleep_mode = 1'b1;
		tick(6);
		cmp_bit("osc enable", 1'b0, osc_out_oe);
		sleep_mode = 1'b0;
		tick(6);
		cmp_bit("osc enable", 1'b1, osc_out_oe);
		report_and_stop();
	end
endmodule
